// ### verilog/pirq_defs.svh
// Offsets, field positions, reset values, vectors and timing counts
// Assumes inclusion by bare name from the interrupt controller files
`ifndef PIRQ_DEFS_SVH
`define PIRQ_DEFS_SVH

// ********
// Register map
// ********
`define PIRQ_ADDR_W 8
`define PIRQ_OPT_OFS 8'h00
`define PIRQ_STAT_OFS 8'h04
`define PIRQ_EVT_OFS 8'h08
`define PIRQ_OPT_RST 8'h00
`define PIRQ_OPT_MASK 8'h70

// ********
// Option fields
// ********
`define PIRQ_LVL_BIT 6
`define PIRQ_POL_BIT 5
`define PIRQ_ENA_BIT 4

// ********
// Status fields
// ********
`define PIRQ_ST_NMI_BIT 0
`define PIRQ_ST_SRC1_BIT 1
`define PIRQ_ST_SRC2_BIT 2
`define PIRQ_ST_SRC3_BIT 3
`define PIRQ_ST_SRC4_BIT 4
`define PIRQ_ST_MODE_LSB 5
`define PIRQ_ST_FSEL_LSB 7
`define PIRQ_ST_PEND_BIT 9
`define PIRQ_ST_OPT_LSB 10

// ********
// Vectors
// ********
`define PIRQ_VEC_SRC0 12'hffc
`define PIRQ_VEC_SRC1 12'hff6
`define PIRQ_VEC_SRC2 12'hff4
`define PIRQ_VEC_SRC3 12'hff2
`define PIRQ_VEC_SRC4 12'hff0

// ********
// Timing
// ********
`define PIRQ_LDI_CYCLES 3'h4
`define PIRQ_DEFECT_CYCLES 3'h3

// ********
// Bus responses
// ********
`define PIRQ_RESP_OKAY 2'h0
`define PIRQ_RESP_SLVERR 2'h2

`endif

// ### verilog/pirq_pkg.sv
// Types shared by the interrupt controller files
// Assumes nothing beyond a SystemVerilog compiler
package pirq_pkg;

   // Execution context, Gray coded along normal, irq, nmi
   typedef enum logic [1:0]
   {
      PIRQ_NORMAL = 2'h0,
      PIRQ_IRQ = 2'h1,
      PIRQ_NMI = 2'h3
   } pirq_mode_e;

   typedef logic [11:0] pirq_vec_t;

endpackage

// ### verilog/pirq_axil_slave.sv
// AXI4-Lite slave front end for the interrupt controller registers
// Assumes one clock and a decoder that answers in the same cycle
`timescale 1ns/1ps
`include "pirq_defs.svh"

module pirq_axil_slave
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Write channels
   input wire logic [`PIRQ_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Read channels
   input wire logic [`PIRQ_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Register side
   output logic wr_en,
   output logic [`PIRQ_ADDR_W-1:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_err,
   output logic rd_en,
   output logic [`PIRQ_ADDR_W-1:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_err
);

   logic aw_full_q, aw_full_d, w_full_q, w_full_d;
   logic [`PIRQ_ADDR_W-1:0] aw_addr_q, aw_addr_d;
   logic [31:0] w_data_q, w_data_d, rdata_q, rdata_d;
   logic [3:0] w_strb_q, w_strb_d;
   logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;

   // ********
   // Handshakes
   // ********
   assign s_axi_awready = ~aw_full_q & ~bvalid_q;
   assign s_axi_wready = ~w_full_q & ~bvalid_q;
   assign s_axi_arready = ~rvalid_q;
   assign wr_en = aw_full_q & w_full_q & ~bvalid_q;
   assign wr_addr = aw_addr_q;
   assign wr_data = w_data_q;
   assign wr_strb = w_strb_q;
   assign rd_en = s_axi_arvalid & s_axi_arready;
   assign rd_addr = s_axi_araddr;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;

   // ********
   // Channel state
   // ********
   always_comb
   begin
      aw_full_d = aw_full_q;
      aw_addr_d = aw_addr_q;
      w_full_d = w_full_q;
      w_data_d = w_data_q;
      w_strb_d = w_strb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      if (s_axi_awvalid & s_axi_awready)
      begin
         aw_full_d = 1'b1;
         aw_addr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
         w_full_d = 1'b1;
         w_data_d = s_axi_wdata;
         w_strb_d = s_axi_wstrb;
      end
      if (wr_en)
      begin
         aw_full_d = 1'b0;
         w_full_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = wr_err ? `PIRQ_RESP_SLVERR : `PIRQ_RESP_OKAY;
      end
      else if (bvalid_q & s_axi_bready)
      begin
         bvalid_d = 1'b0;
      end
      if (rd_en)
      begin
         rvalid_d = 1'b1;
         rdata_d = rd_err ? 32'h0000_0000 : rd_data;
         rresp_d = rd_err ? `PIRQ_RESP_SLVERR : `PIRQ_RESP_OKAY;
      end
      else if (rvalid_q & s_axi_rready)
      begin
         rvalid_d = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         aw_full_q <= 1'b0;
         aw_addr_q <= '0;
         w_full_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `PIRQ_RESP_OKAY;
         rvalid_q <= 1'b0;
         rresp_q <= `PIRQ_RESP_OKAY;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         aw_full_q <= aw_full_d;
         aw_addr_q <= aw_addr_d;
         w_full_q <= w_full_d;
         w_data_q <= w_data_d;
         w_strb_q <= w_strb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
      end
   end

endmodule

// ### verilog/pirq_src_detect.sv
// One pin request source: synchroniser, wired-OR of low-active lines,
// edge detector and pending latch, or plain level pass-through
// Assumes pins asynchronous to clk_sys
`timescale 1ns/1ps

module pirq_src_detect
#(
   parameter int W = 4
)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Pins, active low
   input wire logic [W-1:0] evt_n,
   // Mode
   input wire logic level_mode,
   input wire logic rise_sel,
   // Service start clears the latch
   input wire logic clr,
   // Results
   output logic req,
   output logic [W-1:0] evt_seen
);

   logic [W-1:0] s1_q, s2_q;
   logic low_q, low_d, latch_q, latch_d, line_low, edge_hit;

   // ************************************************************
   // Synchroniser and edge detect
   // ************************************************************
   always_comb
   begin
      line_low = ~(&s2_q);
      low_d = line_low;
      edge_hit = rise_sel ? (~line_low & low_q) : (line_low & ~low_q);
      latch_d = ~level_mode & (edge_hit | (latch_q & ~clr));
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s1_q <= '1;
         s2_q <= '1;
         low_q <= 1'b0;
         latch_q <= 1'b0;
      end
      else
      begin
         s1_q <= evt_n;
         s2_q <= s1_q;
         low_q <= low_d;
         latch_q <= latch_d;
      end
   end

   assign req = level_mode ? line_low : latch_q;
   assign evt_seen = ~s2_q;

endmodule

// ### verilog/pirq_ctrl.sv
// Interrupt controller top: sources, option register, entry and flag pairs
// Assumes a core sequencer on clk_sys pulsing instr_end and returns
//
// Behaviour
// - Four maskable sources and one non-maskable, each with its own vector.
// - Vectors: src0 FFCh, src1 FF6h, src2 FF4h, src3 FF2h, src4 FF0h.
// - On an enabled request the program counter loads that source's vector.
// - Non-maskable preempts normal code and maskable routines, not its own; maskable routines never preempt each other.
// - Pending maskable requests are served in fixed order, source 1 first.
// - Global enable low blocks maskable sources, non-maskable stays active.
// - Global enable also gates wake-up from stop or wait for every source.
// - Non-maskable request is latched and cleared when its routine starts.
// - Source 1 is level sensitive with select set, falling edge otherwise.
// - Source 2 is edge sensitive, polarity bit set selects rising edges.
// - Sources 3 and 4 are level requests with nothing stored.
// - Edge latch holds until its routine starts; extra edges are dropped.
// - Requests sampled at each instruction end; next instruction skipped on entry.
// - Three flag pairs for normal, irq and nmi contexts, switched automatically.
// - Entry swaps flags, pushes PC, inhibits maskable, clears latch, loads vector.
// - Maskable entry early in an option clear keeps the normal flag pair.
// - Several events may share a source, each visible on its own flag.
// - Return restores the previous flag pair and pops the saved PC.
// - Option bits: level select 6, edge polarity 5, global enable 4.
// - Option register is write-only, whole-byte only, resets to zero.
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "pirq_defs.svh"

module pirq_ctrl
#(
   parameter int W1 = 4,
   parameter int W2 = 4,
   parameter int W3 = 4,
   parameter int W4 = 4
)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // AXI4-Lite write
   input wire logic [`PIRQ_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [`PIRQ_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Request pins, active low
   input wire logic nmi_pin_n,
   input wire logic [W1-1:0] src1_pin_n,
   input wire logic [W2-1:0] src2_pin_n,
   // Peripheral requests, active high
   input wire logic [W3-1:0] src3_evt,
   input wire logic [W4-1:0] src4_evt,
   // Core sequencer
   input wire logic instr_end,
   input wire logic return_from_irq,
   input wire logic flag_we,
   input wire logic flag_c_in,
   input wire logic flag_z_in,
   // Core control
   output logic skip_next,
   output logic pc_push,
   output logic pc_load,
   output pirq_pkg::pirq_vec_t vector_addr,
   output logic pc_pop,
   output logic carry_flag,
   output logic zero_flag,
   output pirq_pkg::pirq_mode_e irq_mode,
   output logic wake_req
);
   import pirq_pkg::*;

   logic wr_en, wr_err, rd_err;
   logic [`PIRQ_ADDR_W-1:0] wr_addr, rd_addr;
   logic [31:0] wr_data, rd_data;
   logic [3:0] wr_strb;
   logic [7:0] opt_q, opt_d, pend_data_q, pend_data_d;
   logic pend_q, pend_d;
   logic [2:0] pend_cnt_q, pend_cnt_d;
   logic global_irq_enable, level_edge_select, edge_polarity_select, defect_win;
   logic nmi_req, r1, r2, r3, r4, nmi_ok, mask_ok, take;
   logic clr0, clr1, clr2;
   logic [W1-1:0] e1;
   logic [W2-1:0] e2;
   logic [2:0] sel;
   pirq_mode_e mode_q, mode_d, fsel_q, fsel_d, save_mode_q, save_mode_d;
   pirq_mode_e save_fsel_q, save_fsel_d;
   logic [1:0] cz_q [3];
   logic [1:0] cz_d [3];
   logic push_q, push_d, pop_q, pop_d;
   pirq_vec_t vec_q, vec_d;

   function automatic pirq_vec_t vec_of(input logic [2:0] s);
      pirq_vec_t v;
      v = `PIRQ_VEC_SRC4;
      unique case (s)
         3'h0: v = `PIRQ_VEC_SRC0;
         3'h1: v = `PIRQ_VEC_SRC1;
         3'h2: v = `PIRQ_VEC_SRC2;
         3'h3: v = `PIRQ_VEC_SRC3;
         default: v = `PIRQ_VEC_SRC4;
      endcase
      return v;
   endfunction

   // Flag pair index of a context
   function automatic logic [1:0] pair_of(input pirq_mode_e m);
      logic [1:0] i;
      i = 2'h0;
      unique case (m)
         PIRQ_NORMAL: i = 2'h0;
         PIRQ_IRQ: i = 2'h1;
         PIRQ_NMI: i = 2'h2;
         default: i = 2'h0;
      endcase
      return i;
   endfunction

   // ********
   // Bus front end
   // ********
   pirq_axil_slave u_bus
   (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_err(wr_err),
      .rd_en(),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_err(rd_err)
   );

   // ********
   // Register decode
   // ********
   // Whole-byte write only
   assign wr_err = (wr_addr != `PIRQ_OPT_OFS) | ~wr_strb[0];

   always_comb
   begin
      logic [31:0] ev;
      ev = 32'h0000_0000;
      rd_data = 32'h0000_0000;
      rd_err = 1'b1;
      if (rd_addr == `PIRQ_STAT_OFS)
      begin
         rd_err = 1'b0;
         rd_data[`PIRQ_ST_NMI_BIT] = nmi_req;
         rd_data[`PIRQ_ST_SRC1_BIT] = r1;
         rd_data[`PIRQ_ST_SRC2_BIT] = r2;
         rd_data[`PIRQ_ST_SRC3_BIT] = r3;
         rd_data[`PIRQ_ST_SRC4_BIT] = r4;
         rd_data[`PIRQ_ST_MODE_LSB +: 2] = mode_q;
         rd_data[`PIRQ_ST_FSEL_LSB +: 2] = fsel_q;
         rd_data[`PIRQ_ST_PEND_BIT] = pend_q;
         rd_data[`PIRQ_ST_OPT_LSB +: 3] = {level_edge_select, edge_polarity_select,
            global_irq_enable};
      end
      else if (rd_addr == `PIRQ_EVT_OFS)
      begin
         rd_err = 1'b0;
         ev[W1-1:0] = e1;
         ev[8 +: W2] = e2;
         ev[16 +: W3] = src3_evt;
         ev[24 +: W4] = src4_evt;
         rd_data = ev;
      end
   end

   // ********
   // Option register with four-cycle load
   // ********
   always_comb
   begin
      opt_d = opt_q;
      pend_d = pend_q;
      pend_cnt_d = pend_cnt_q;
      pend_data_d = pend_data_q;
      if (wr_en & ~wr_err)
      begin
         pend_d = 1'b1;
         pend_cnt_d = 3'h1;
         pend_data_d = wr_data[7:0];
      end
      else if (pend_q & (pend_cnt_q == `PIRQ_LDI_CYCLES))
      begin
         // Only the three used bits stored
         opt_d = pend_data_q & `PIRQ_OPT_MASK;
         pend_d = 1'b0;
      end
      else if (pend_q)
      begin
         pend_cnt_d = pend_cnt_q + 3'h1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         opt_q <= `PIRQ_OPT_RST;
         pend_q <= 1'b0;
         pend_cnt_q <= 3'h0;
         pend_data_q <= 8'h00;
      end
      else
      begin
         opt_q <= opt_d;
         pend_q <= pend_d;
         pend_cnt_q <= pend_cnt_d;
         pend_data_q <= pend_data_d;
      end
   end

   assign global_irq_enable = opt_q[`PIRQ_ENA_BIT];
   assign level_edge_select = opt_q[`PIRQ_LVL_BIT];
   assign edge_polarity_select = opt_q[`PIRQ_POL_BIT];
   assign defect_win = pend_q & (pend_data_q == 8'h00) & (pend_cnt_q <= `PIRQ_DEFECT_CYCLES);

   // ********
   // Sources
   // ********
   // Nmi and four maskable sources
   pirq_src_detect #(.W(1)) u_src0
   (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .evt_n(nmi_pin_n),
      .level_mode(1'b0),
      .rise_sel(1'b0),
      .clr(clr0),
      .req(nmi_req),
      .evt_seen()
   );

   pirq_src_detect #(.W(W1)) u_src1
   (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .evt_n(src1_pin_n),
      .level_mode(level_edge_select),
      .rise_sel(1'b0),
      .clr(clr1),
      .req(r1),
      .evt_seen(e1)
   );

   pirq_src_detect #(.W(W2)) u_src2
   (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .evt_n(src2_pin_n),
      .level_mode(1'b0),
      .rise_sel(edge_polarity_select),
      .clr(clr2),
      .req(r2),
      .evt_seen(e2)
   );

   assign r3 = |src3_evt;
   assign r4 = |src4_evt;

   // ********
   // Arbitration at instruction end
   // ********
   // Nmi preempts, maskable only from normal
   assign nmi_ok = nmi_req & (mode_q != PIRQ_NMI);
   assign mask_ok = global_irq_enable & (mode_q == PIRQ_NORMAL) & (r1 | r2 | r3 | r4);
   assign take = instr_end & ~return_from_irq & (nmi_ok | mask_ok);
   assign sel = nmi_ok ? 3'h0 : r1 ? 3'h1 : r2 ? 3'h2 : r3 ? 3'h3 : 3'h4;
   assign clr0 = take & (sel == 3'h0);
   assign clr1 = take & (sel == 3'h1);
   assign clr2 = take & (sel == 3'h2);
   assign skip_next = take;
   assign wake_req = global_irq_enable & (nmi_req | r1 | r2 | r3 | r4);

   // ********
   // Context, flags and core strobes
   // ********
   always_comb
   begin
      mode_d = mode_q;
      fsel_d = fsel_q;
      save_mode_d = save_mode_q;
      save_fsel_d = save_fsel_q;
      cz_d = cz_q;
      push_d = take;
      pop_d = return_from_irq;
      vec_d = vec_q;
      if (flag_we)
      begin
         cz_d[pair_of(fsel_q)] = {flag_c_in, flag_z_in};
      end
      if (take)
      begin
         vec_d = vec_of(sel);
         if (sel == 3'h0)
         begin
            save_mode_d = mode_q;
            save_fsel_d = fsel_q;
            mode_d = PIRQ_NMI;
            fsel_d = PIRQ_NMI;
         end
         else
         begin
            mode_d = PIRQ_IRQ;
            fsel_d = defect_win ? PIRQ_NORMAL : PIRQ_IRQ;
         end
      end
      else if (return_from_irq)
      begin
         if (mode_q == PIRQ_NMI)
         begin
            mode_d = save_mode_q;
            fsel_d = save_fsel_q;
         end
         else
         begin
            mode_d = PIRQ_NORMAL;
            fsel_d = PIRQ_NORMAL;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mode_q <= PIRQ_NORMAL;
         fsel_q <= PIRQ_NORMAL;
         save_mode_q <= PIRQ_NORMAL;
         save_fsel_q <= PIRQ_NORMAL;
         cz_q <= '{2'h0, 2'h0, 2'h0};
         push_q <= 1'b0;
         pop_q <= 1'b0;
         vec_q <= `PIRQ_VEC_SRC4;
      end
      else
      begin
         mode_q <= mode_d;
         fsel_q <= fsel_d;
         save_mode_q <= save_mode_d;
         save_fsel_q <= save_fsel_d;
         cz_q <= cz_d;
         push_q <= push_d;
         pop_q <= pop_d;
         vec_q <= vec_d;
      end
   end

   assign carry_flag = cz_q[pair_of(fsel_q)][1];
   assign zero_flag = cz_q[pair_of(fsel_q)][0];
   // Push then load in one strobe cycle
   assign pc_push = push_q;
   assign pc_load = push_q;
   assign vector_addr = vec_q;
   assign pc_pop = pop_q;
   assign irq_mode = mode_q;

endmodule

// ### bench/pirq_core_mdl.sv
// Core sequencer model: instruction end every fourth cycle, return on request
// Assumes a bench that holds ret_req until it sees pc_pop
`timescale 1ns/1ps

module pirq_core_mdl
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Bench command
   input wire logic ret_req,
   // Sequencer outputs
   output logic instr_end,
   output logic return_from_irq
);
   logic [1:0] cnt_q;

   // ********
   // Instruction timing
   // ********
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         cnt_q <= 2'h0;
      else
         cnt_q <= cnt_q + 2'h1;
   end
   assign instr_end = (cnt_q == 2'h3);
   assign return_from_irq = ret_req && (cnt_q == 2'h1);
endmodule

// ### bench/pirq_ctrl_properties.sv
// Checker of the core-side ports of the controller
// Assumes binding into pirq_ctrl
`timescale 1ns/1ps
`include "pirq_defs.svh"

module pirq_ctrl_chk
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Core link
   input wire logic instr_end,
   input wire logic return_from_irq,
   input wire logic skip_next,
   input wire logic pc_push,
   input wire logic pc_load,
   input wire logic pc_pop,
   input wire pirq_pkg::pirq_vec_t vector_addr,
   input wire pirq_pkg::pirq_mode_e irq_mode
);
   import pirq_pkg::*;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   // ********
   // Properties
   // ********
   AST_SKIP: assert property (skip_next |-> instr_end && !return_from_irq)
      else $error("skip outside instruction end");
   AST_ENTRY: assert property (skip_next |=> pc_push && pc_load)
      else $error("entry without push and load");
   AST_CAUSE: assert property (pc_load |-> $past(skip_next))
      else $error("load without entry");
   AST_VEC: assert property (pc_load |-> vector_addr inside {`PIRQ_VEC_SRC0,
      `PIRQ_VEC_SRC1, `PIRQ_VEC_SRC2, `PIRQ_VEC_SRC3, `PIRQ_VEC_SRC4})
      else $error("bad vector");
   AST_NMI: assert property (pc_load && vector_addr == `PIRQ_VEC_SRC0 |->
      irq_mode == PIRQ_NMI) else $error("nmi entry mode wrong");
   AST_NOPRE: assert property (pc_load && vector_addr != `PIRQ_VEC_SRC0 |->
      $past(irq_mode) == PIRQ_NORMAL) else $error("maskable preempted");
   AST_POP: assert property (return_from_irq |=> pc_pop)
      else $error("return without pop");
   AST_HOLD: assert property (!pc_load |-> $stable(vector_addr))
      else $error("vector moved");
   AST_MODE: assert property ($changed(irq_mode) |-> pc_load || $past(return_from_irq))
      else $error("mode changed alone");
endmodule

bind pirq_ctrl pirq_ctrl_chk i_pirq_ctrl_chk (.clk_sys, .rst_b, .instr_end,
   .return_from_irq, .skip_next, .pc_push, .pc_load, .pc_pop, .vector_addr, .irq_mode);

// ### bench/prioritized_irq_controller_bench.sv
// Self-checking bench of the interrupt controller
// Assumes design files, core model and checker compiled first
`timescale 1ns/1ps
`include "pirq_defs.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
   $display("[ERR] %0t got %h exp %h", $time, a, b); end end

module prioritized_irq_controller_bench;
   import pirq_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic nmi_pin_n = 1'b1;
   logic [3:0] src1_pin_n = 4'hf, src2_pin_n = 4'hf, src3_evt = 4'h0, src4_evt = 4'h0;
   logic flag_we = 1'b0, flag_c_in = 1'b0, flag_z_in = 1'b0, ret_req = 1'b0;
   logic instr_end, return_from_irq, skip_next, pc_push, pc_load, pc_pop;
   logic carry_flag, zero_flag, wake_req;
   pirq_vec_t vector_addr;
   pirq_mode_e irq_mode;
   int fails = 0, check_count = 0;

   always #2 clk_sys = ~clk_sys;

   pirq_ctrl i_pirq_ctrl
   (
      .clk_sys, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nmi_pin_n, .src1_pin_n, .src2_pin_n,
      .src3_evt, .src4_evt, .instr_end, .return_from_irq, .flag_we, .flag_c_in,
      .flag_z_in, .skip_next, .pc_push, .pc_load, .vector_addr, .pc_pop, .carry_flag,
      .zero_flag, .irq_mode, .wake_req
   );
   pirq_core_mdl i_pirq_core_mdl (.clk_sys, .rst_b, .ret_req, .instr_end, .return_from_irq);

   // ********
   // Tasks
   // ********
   task automatic wrap_up;
      $display("mismatches %0d comparisons %0d", fails, check_count);
      if (fails == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic tmo(input int n);
      if (n >= 60)
      begin
         fails++;
         wrap_up;
      end
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      int n;
      logic ta, tw, tb;
      logic [1:0] r;
      n = 0;
      tb = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!tb && n < 60)
      begin
         @(negedge clk_sys);
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         tb = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge clk_sys);
         if (ta)
            s_axi_awvalid <= 1'b0;
         if (tw)
            s_axi_wvalid <= 1'b0;
         n++;
      end
      tmo(n);
      `CHK(r, e)
   endtask

   task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      int n;
      logic ta, tr;
      logic [33:0] r;
      n = 0;
      tr = 1'b0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      while (!tr && n < 60)
      begin
         @(negedge clk_sys);
         ta = s_axi_arvalid & s_axi_arready;
         tr = s_axi_rvalid;
         r = {s_axi_rresp, s_axi_rdata};
         @(posedge clk_sys);
         if (ta)
            s_axi_arvalid <= 1'b0;
         n++;
      end
      tmo(n);
      `CHK(r, {e, d})
   endtask

   task automatic entry(input pirq_vec_t v, input pirq_mode_e m);
      int n;
      n = 0;
      do
      begin
         @(negedge clk_sys);
         n++;
      end while (pc_load !== 1'b1 && n < 60);
      tmo(n);
      `CHK({vector_addr, irq_mode}, {v, m})
      @(posedge clk_sys);
   endtask

   task automatic ret;
      int n;
      n = 0;
      ret_req <= 1'b1;
      do
      begin
         @(negedge clk_sys);
         n++;
      end while (pc_pop !== 1'b1 && n < 60);
      @(posedge clk_sys);
      ret_req <= 1'b0;
      tmo(n);
   endtask

   task automatic quiet;
      repeat (20) @(negedge clk_sys);
      `CHK({irq_mode, wake_req}, {PIRQ_NORMAL, 1'b0})
      @(posedge clk_sys);
   endtask

   // ********
   // Tests
   // ********
   initial
   begin
      repeat (12) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      axr(`PIRQ_OPT_OFS, 32'h0, `PIRQ_RESP_SLVERR);
      axr(`PIRQ_STAT_OFS, 32'h0, `PIRQ_RESP_OKAY);
      axw(8'h0c, 32'h10, `PIRQ_RESP_SLVERR);
      $display("test reset done");
      src3_evt <= 4'h1;
      quiet;
      nmi_pin_n <= 1'b0;
      entry(`PIRQ_VEC_SRC0, PIRQ_NMI);
      nmi_pin_n <= 1'b1;
      ret;
      $display("test masking done");
      src1_pin_n <= 4'hd;
      src4_evt <= 4'h2;
      repeat (4) @(posedge clk_sys);
      axr(`PIRQ_EVT_OFS, 32'h02010002, `PIRQ_RESP_OKAY);
      axw(`PIRQ_OPT_OFS, 32'h10, `PIRQ_RESP_OKAY);
      entry(`PIRQ_VEC_SRC1, PIRQ_IRQ);
      src1_pin_n <= 4'hf;
      flag_c_in <= 1'b1;
      flag_we <= 1'b1;
      @(posedge clk_sys);
      flag_we <= 1'b0;
      @(negedge clk_sys);
      `CHK(carry_flag, 1'b1)
      `CHK(wake_req, 1'b1)
      @(posedge clk_sys);
      ret;
      @(negedge clk_sys);
      `CHK(carry_flag, 1'b0)
      @(posedge clk_sys);
      entry(`PIRQ_VEC_SRC3, PIRQ_IRQ);
      src3_evt <= 4'h0;
      ret;
      entry(`PIRQ_VEC_SRC4, PIRQ_IRQ);
      src4_evt <= 4'h0;
      src3_evt <= 4'h1;
      repeat (4) @(posedge clk_sys);
      src3_evt <= 4'h0;
      ret;
      quiet;
      $display("test priority done");
      axw(`PIRQ_OPT_OFS, 32'h30, `PIRQ_RESP_OKAY);
      repeat (4) @(posedge clk_sys);
      src2_pin_n <= 4'h7;
      quiet;
      src2_pin_n <= 4'hf;
      entry(`PIRQ_VEC_SRC2, PIRQ_IRQ);
      repeat (2)
      begin
         src2_pin_n <= 4'h7;
         repeat (4) @(posedge clk_sys);
         src2_pin_n <= 4'hf;
         repeat (4) @(posedge clk_sys);
      end
      ret;
      entry(`PIRQ_VEC_SRC2, PIRQ_IRQ);
      ret;
      quiet;
      axw(`PIRQ_OPT_OFS, 32'h50, `PIRQ_RESP_OKAY);
      repeat (4) @(posedge clk_sys);
      src1_pin_n <= 4'h7;
      entry(`PIRQ_VEC_SRC1, PIRQ_IRQ);
      ret;
      entry(`PIRQ_VEC_SRC1, PIRQ_IRQ);
      src1_pin_n <= 4'hf;
      ret;
      quiet;
      // Option cleared while a request waits
      @(negedge clk_sys);
      for (int i = 0; i < 3 && !instr_end; i++)
         @(negedge clk_sys);
      @(posedge clk_sys);
      src3_evt <= 4'h1;
      axw(`PIRQ_OPT_OFS, 32'h0, `PIRQ_RESP_OKAY);
      entry(`PIRQ_VEC_SRC3, PIRQ_IRQ);
      @(negedge clk_sys);
      `CHK({carry_flag, zero_flag}, 2'b00)
      @(posedge clk_sys);
      ret;
      quiet;
      $display("test modes done");
      wrap_up;
   end
endmodule
